// >>> pkg/irq_enable_pending_regs.vh
// offsets, field layouts, masks and reset values of the interrupt enable/pending slice
// Function
// RULE1: channel 1 handler address bits 31..1 read-write
// RULE2: bit 0 switches fast channel 1 on
// RULE3: enable-set low word sets enables
// RULE4: enable-set high word sets irqs 32-38
// RULE5: enable-clear low word clears enables
// RULE6: enable-clear high word clears irqs 32-38
// RULE7: pending-set low word marks 12,14,16-31
// RULE8: pending-set bits 2,3 mark irqs 2,3
// RULE9: eight-bit field picks channel 1 irq number
// RULE10: pending-clear write-one clears pending flag
// RULE11: shared enable flag, clear beats set
`ifndef IRQ_ENABLE_PENDING_REGS_VH
`define IRQ_ENABLE_PENDING_REGS_VH

`define NUM_IRQ        39
`define ADDR_W         12

`define OFF_FV_ID      12'h050
`define OFF_FV1_ADDR   12'h064
`define OFF_EN_SET_LO  12'h100
`define OFF_EN_SET_HI  12'h104
`define OFF_EN_CLR_LO  12'h180
`define OFF_EN_CLR_HI  12'h184
`define OFF_PD_SET_LO  12'h200
`define OFF_PD_SET_HI  12'h204
`define OFF_PD_CLR_LO  12'h280
`define OFF_PD_CLR_HI  12'h284

`define FV_ID_LSB      8
`define FV_ID_MSB      15

`define EN_LO_MASK     32'hFFFF5000
`define PD_LO_MASK     32'hFFFF500C
`define HI_MASK        32'h0000007F

`define RST_ADDR       31'h00000000
`define RST_ID         8'h00
`define RST_ON         1'b0
`define RST_FLAGS      39'h0000000000

`define RESP_OKAY      2'b00
`define RESP_DECERR    2'b11

`endif

// >>> rtl/irq_flag_bank.v
// per-interrupt enable and pending flags with their set/clear priorities
`include "irq_enable_pending_regs.vh"

module irq_flag_bank (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [38:0] enSet,
  input  wire [38:0] enClr,
  input  wire [38:0] pdSet,
  input  wire [38:0] pdClr,
  input  wire [38:0] hwEvent,
  input  wire [38:0] irqTaken,
  output wire [38:0] enFlags,
  output wire [38:0] pdFlags
);

  genvar i;
  generate
    for (i = 0; i < `NUM_IRQ; i = i + 1) begin : gFlag
      // one flop pair per irq, so each flag has a single driving process
      reg en_r;
      reg pd_r;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          en_r <= 1'b0;
          pd_r <= 1'b0;
        end else begin
          if (enClr[i]) begin
            en_r <= 1'b0; // see RULE11
          end else if (enSet[i]) begin
            en_r <= 1'b1;
          end
          // an event in the clearing cycle must not be lost
          if (pdSet[i] || hwEvent[i]) begin
            pd_r <= 1'b1;
          end else if (pdClr[i] || irqTaken[i]) begin
            pd_r <= 1'b0; // see RULE10
          end
        end
      end
      assign enFlags[i] = en_r;
      assign pdFlags[i] = pd_r;
    end
  endgenerate

endmodule // irq_flag_bank

// >>> rtl/irq_enable_pending_regs.v
// axi4-lite register slice: fast channel 1 and irq enable/pending
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "irq_enable_pending_regs.vh"

module irq_enable_pending_regs (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [38:0] hwEvent,
  input  wire [38:0] irqTaken,
  output wire [38:0] irqEnable,
  output wire [38:0] irqPending,
  output wire [38:0] irqRequest,
  output wire        fastCh1On,
  output wire [31:0] fastCh1HandlerAddr,
  output wire [7:0]  fastCh1IrqNumber
);

  reg  [11:0] awAddr_r;
  reg         awHeld_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg         wHeld_r;
  reg         bValid_r;
  reg  [1:0]  bResp_r;
  reg  [31:0] rData_r;
  reg  [1:0]  rResp_r;
  reg         rValid_r;

  reg  [30:0] fvAddr_r;
  reg         fvOn_r;
  reg  [7:0]  fvNum_r;

  reg  [38:0] enSet;
  reg  [38:0] enClr;
  reg  [38:0] pdSet;
  reg  [38:0] pdClr;
  reg         wrHit;

  wire        wrFire;
  wire        rdFire;
  wire [31:0] byteMask;
  wire [31:0] w1;
  wire [31:0] fvWord;
  wire [38:0] enFlags;
  wire [38:0] pdFlags;

  // one write in flight: address and data held until the response
  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign wrFire        = awHeld_r && wHeld_r && !bValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;

  // new read only once the previous data were taken
  assign s_axi_arready = !rValid_r;
  assign rdFire        = s_axi_arvalid && !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  assign byteMask = {{8{wStrb_r[3]}},
                     {8{wStrb_r[2]}},
                     {8{wStrb_r[1]}},
                     {8{wStrb_r[0]}}};
  // write-one bits only act in lanes actually written
  assign w1 = wData_r & byteMask;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awAddr_r <= 12'h000;
      awHeld_r <= 1'b0;
    end else if (s_axi_awvalid && !awHeld_r) begin
      awAddr_r <= s_axi_awaddr;
      awHeld_r <= 1'b1;
    end else if (wrFire) begin
      awHeld_r <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      wHeld_r <= 1'b0;
    end else if (s_axi_wvalid && !wHeld_r) begin
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
      wHeld_r <= 1'b1;
    end else if (wrFire) begin
      wHeld_r <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bValid_r <= 1'b0;
      bResp_r  <= `RESP_OKAY;
    end else if (wrFire) begin
      bValid_r <= 1'b1;
      bResp_r  <= wrHit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // write decode into one-cycle set/clear strobes
  always @* begin
    enSet = `RST_FLAGS;
    enClr = `RST_FLAGS;
    pdSet = `RST_FLAGS;
    pdClr = `RST_FLAGS;
    wrHit = 1'b1;
    if (awAddr_r == `OFF_FV_ID) begin
      wrHit = 1'b1;
    end else if (awAddr_r == `OFF_FV1_ADDR) begin
      wrHit = 1'b1;
    end else if (awAddr_r == `OFF_EN_SET_LO) begin
      if (wrFire) begin
        enSet[31:0] = w1 & `EN_LO_MASK; // see RULE3
      end
    end else if (awAddr_r == `OFF_EN_SET_HI) begin
      if (wrFire) begin
        enSet[38:32] = w1[6:0]; // see RULE4
      end
    end else if (awAddr_r == `OFF_EN_CLR_LO) begin
      if (wrFire) begin
        enClr[31:0] = w1 & `EN_LO_MASK; // see RULE5
      end
    end else if (awAddr_r == `OFF_EN_CLR_HI) begin
      if (wrFire) begin
        enClr[38:32] = w1[6:0]; // see RULE6
      end
    end else if (awAddr_r == `OFF_PD_SET_LO) begin
      if (wrFire) begin
        // bits 2 and 3 included, 1..0 and 11..4 dropped
        pdSet[31:0] = w1 & `PD_LO_MASK; // see RULE7 see RULE8
      end
    end else if (awAddr_r == `OFF_PD_SET_HI) begin
      if (wrFire) begin
        pdSet[38:32] = w1[6:0];
      end
    end else if (awAddr_r == `OFF_PD_CLR_LO) begin
      if (wrFire) begin
        pdClr[31:0] = w1 & `PD_LO_MASK; // see RULE10
      end
    end else if (awAddr_r == `OFF_PD_CLR_HI) begin
      if (wrFire) begin
        pdClr[38:32] = w1[6:0]; // see RULE10
      end
    end else begin
      wrHit = 1'b0;
    end
  end

  // fast channel 1: handler address, on bit, irq number
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fvAddr_r <= `RST_ADDR;
      fvOn_r   <= `RST_ON;
      fvNum_r  <= `RST_ID;
    end else if (wrFire) begin
      if (awAddr_r == `OFF_FV1_ADDR) begin
        if (wStrb_r[0]) begin
          fvOn_r       <= wData_r[0]; // see RULE2
          fvAddr_r[6:0] <= wData_r[7:1]; // see RULE1
        end
        if (wStrb_r[1]) begin
          fvAddr_r[14:7] <= wData_r[15:8]; // see RULE1
        end
        if (wStrb_r[2]) begin
          fvAddr_r[22:15] <= wData_r[23:16]; // see RULE1
        end
        if (wStrb_r[3]) begin
          fvAddr_r[30:23] <= wData_r[31:24]; // see RULE1
        end
      end else if (awAddr_r == `OFF_FV_ID) begin
        if (wStrb_r[1]) begin
          fvNum_r <= wData_r[`FV_ID_MSB:`FV_ID_LSB]; // see RULE9
        end
      end
    end
  end

  assign fvWord = {fvAddr_r, fvOn_r};

  // reads: set registers show the live flags, clear registers read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h00000000;
      rResp_r  <= `RESP_OKAY;
    end else if (rdFire) begin
      rValid_r <= 1'b1;
      rResp_r  <= `RESP_OKAY;
      rData_r  <= 32'h00000000;
      if (s_axi_araddr == `OFF_FV1_ADDR) begin
        rData_r <= fvWord;
      end else if (s_axi_araddr == `OFF_FV_ID) begin
        rData_r[`FV_ID_MSB:`FV_ID_LSB] <= fvNum_r;
      end else if (s_axi_araddr == `OFF_EN_SET_LO) begin
        rData_r <= enFlags[31:0] & `EN_LO_MASK;
      end else if (s_axi_araddr == `OFF_EN_SET_HI) begin
        rData_r[6:0] <= enFlags[38:32];
      end else if (s_axi_araddr == `OFF_PD_SET_LO) begin
        rData_r <= pdFlags[31:0] & `PD_LO_MASK;
      end else if (s_axi_araddr == `OFF_PD_SET_HI) begin
        rData_r[6:0] <= pdFlags[38:32];
      end else if (s_axi_araddr == `OFF_EN_CLR_LO) begin
        rData_r <= 32'h00000000;
      end else if (s_axi_araddr == `OFF_EN_CLR_HI) begin
        rData_r <= 32'h00000000;
      end else if (s_axi_araddr == `OFF_PD_CLR_LO) begin
        rData_r <= 32'h00000000;
      end else if (s_axi_araddr == `OFF_PD_CLR_HI) begin
        rData_r <= 32'h00000000;
      end else begin
        rResp_r <= `RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  irq_flag_bank uFlags (
    .clk      (clk),
    .rst_n    (rst_n),
    .enSet    (enSet),
    .enClr    (enClr),
    .pdSet    (pdSet),
    .pdClr    (pdClr),
    .hwEvent  (hwEvent),
    .irqTaken (irqTaken),
    .enFlags  (enFlags),
    .pdFlags  (pdFlags)
  );

  assign irqEnable          = enFlags;
  assign irqPending         = pdFlags;
  // the core sees only what is both enabled and pending
  assign irqRequest         = enFlags & pdFlags;
  // handler entry is halfword aligned, bit 0 is never set
  assign fastCh1HandlerAddr = {fvAddr_r, 1'b0}; // see RULE1
  assign fastCh1On          = fvOn_r;
  assign fastCh1IrqNumber   = fvNum_r;

endmodule // irq_enable_pending_regs

// >>> dv/irq_enable_pending_regs_assertions.sv
// checker for the irq enable/pending register slice
module irq_enable_pending_regs_checker (
  input logic        clk,
  input logic        rst_n,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic [38:0] irqEnable,
  input logic [38:0] irqPending,
  input logic [38:0] irqRequest,
  input logic        fastCh1On,
  input logic [31:0] fastCh1HandlerAddr,
  input logic [7:0]  fastCh1IrqNumber
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REQ_AND: assert property (irqRequest == (irqEnable & irqPending))
    else $error("request is not enable and pending");
  AST_ADDR_BIT0: assert property (fastCh1HandlerAddr[0] == 1'b0)
    else $error("handler address bit 0 set");
  AST_ON_AT_WRITE: assert property ($changed(fastCh1On) |-> $rose(s_axi_bvalid))
    else $error("channel on changed without a write");
  AST_ID_AT_WRITE: assert property ($changed(fastCh1IrqNumber) |-> $rose(s_axi_bvalid))
    else $error("channel irq number changed without a write");
  AST_EN_AT_WRITE: assert property ($changed(irqEnable) |-> $rose(s_axi_bvalid))
    else $error("enable flags changed without a write");
  AST_EN_RESV: assert property ((irqEnable[15:0] & 16'hAFFF) == 16'h0000)
    else $error("reserved enable bit set");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  cover property ($rose(fastCh1On));
  cover property ($rose(|irqRequest));
  cover property (s_axi_bvalid && s_axi_bresp == 2'b11);
endmodule // irq_enable_pending_regs_checker

bind irq_enable_pending_regs irq_enable_pending_regs_checker u_irq_enable_pending_regs_checker (
  .clk(clk), .rst_n(rst_n), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .irqEnable(irqEnable), .irqPending(irqPending),
  .irqRequest(irqRequest), .fastCh1On(fastCh1On), .fastCh1HandlerAddr(fastCh1HandlerAddr),
  .fastCh1IrqNumber(fastCh1IrqNumber));

// >>> dv/irq_core_model.sv
// core model that takes the lowest requested irq after a delay
module irq_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic [38:0] irqRequest,
  output logic      [38:0] irqTaken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqTaken <= 39'h0;
      cnt_r    <= 4'h0;
    end else begin
      irqTaken <= 39'h0;
      // one take at a time, the pulse must clear before the next
      if (irqRequest != 39'h0 && irqTaken == 39'h0) begin
        if (cnt_r >= (slow ? 4'h6 : 4'h0)) begin
          irqTaken <= irqRequest & (~irqRequest + 39'h1);
          cnt_r    <= 4'h0;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule // irq_core_model

// >>> dv/irq_enable_pending_regs_test.sv
// self-checking bench for the irq enable/pending register slice
module irq_enable_pending_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, awValid, wValid, bReady, arValid, rReady, slow;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rnd;
  logic [38:0] hwEvent;
  logic [3:0]  wStrb;
  wire         awReady, wReady, bValid, arReady, rValid, fastCh1On;
  wire  [1:0]  bResp, rResp;
  wire  [31:0] rData, fastCh1HandlerAddr;
  wire  [38:0] irqTaken, irqEnable, irqPending, irqRequest;
  wire  [7:0]  fastCh1IrqNumber;
  logic [38:0] rq[$], bq[$];
  int          mismatches, nTests;

  irq_enable_pending_regs u_irq_enable_pending_regs (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .hwEvent(hwEvent), .irqTaken(irqTaken), .irqEnable(irqEnable), .irqPending(irqPending),
    .irqRequest(irqRequest), .fastCh1On(fastCh1On),
    .fastCh1HandlerAddr(fastCh1HandlerAddr), .fastCh1IrqNumber(fastCh1IrqNumber));
  irq_core_model u_irq_core_model (.clk(clk), .rst_n(rst_n), .slow(slow),
    .irqRequest(irqRequest), .irqTaken(irqTaken));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [38:0] e, input logic [38:0] g);
    nTests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tb, tv;
    @(posedge clk);
    bq.push_back(39'(r));
    awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1;
    // bready follows bvalid, so every response is made to wait one cycle
    do begin
      @(negedge clk);
      ta = awValid && awReady; tw = wValid && wReady;
      tv = bValid;
      tb = bValid && bReady;
      @(posedge clk);
      if (ta) awValid <= 1'b0;
      if (tw) wValid <= 1'b0;
      if (tv && !tb) bReady <= 1'b1;
    end while (!tb);
    bReady <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    rq.push_back(39'({r, d}));
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    do begin
      @(negedge clk);
      ta = arValid && arReady; tr = rValid;
      @(posedge clk);
      if (ta) arValid <= 1'b0;
    end while (!tr);
    rReady <= 1'b0;
  endtask
  task automatic close_out;
    if (mismatches == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // results are judged at the negedge before the handshake edge
  always @(negedge clk) begin
    if (rValid && rReady) chk("rdata", rq.pop_front(), 39'({rResp, rData}));
    if (bValid && bReady) chk("bresp", bq.pop_front(), 39'(bResp));
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    close_out;
  end
  initial begin
    rst_n = 1'b0; awValid = 1'b0; wValid = 1'b0; bReady = 1'b0; arValid = 1'b0;
    rReady = 1'b0; slow = 1'b0; awAddr = 12'h000; arAddr = 12'h000; wData = 32'h0;
    hwEvent = 39'h0; rnd = 32'hB6755F57; wStrb = 4'hF;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h064, 32'h0, 2'h0);
    rd(12'h050, 32'h0, 2'h0);
    rnd = lfsr(rnd);
    wr(12'h064, rnd | 32'h1, 2'h0);
    chk("addr", {rnd[31:1], 1'b0}, fastCh1HandlerAddr);
    chk("on", 1'b1, fastCh1On);
    rd(12'h064, rnd | 32'h1, 2'h0);
    wr(12'h064, rnd & 32'hFFFFFFFE, 2'h0);
    chk("on", 1'b0, fastCh1On);
    wr(12'h050, 32'h0000AB00, 2'h0);
    chk("irqnum", 8'hAB, fastCh1IrqNumber);
    // lane 1 left unstrobed: the irq number must keep its value
    wStrb <= 4'h1;
    wr(12'h050, 32'h00005500, 2'h0);
    wStrb <= 4'hF;
    chk("irqnum", 8'hAB, fastCh1IrqNumber);
    wr(12'h100, 32'hFFFFFFFF, 2'h0);
    wr(12'h104, 32'hFFFFFFFF, 2'h0);
    chk("enable", 39'h7FFFFF5000, irqEnable);
    rd(12'h104, 32'h7F, 2'h0);
    rnd = lfsr(rnd);
    wr(12'h180, rnd, 2'h0);
    rd(12'h100, 32'hFFFF5000 & ~rnd, 2'h0);
    wr(12'h184, 32'h55, 2'h0);
    chk("enable", 7'h2A, irqEnable[38:32]);
    wr(12'h180, 32'hFFFFFFFF, 2'h0);
    wr(12'h184, 32'hFFFFFFFF, 2'h0);
    chk("enable", 39'h0, irqEnable);
    wr(12'h200, 32'hFFFFFFFF, 2'h0);
    wr(12'h204, 32'hFFFFFFFF, 2'h0);
    rd(12'h200, 32'hFFFF500C, 2'h0);
    chk("pending", 39'h7FFFFF500C, irqPending);
    wr(12'h280, 32'hFFFFFFFF, 2'h0);
    wr(12'h284, 32'h7F, 2'h0);
    chk("pending", 39'h0, irqPending);
    rd(12'h7FC, 32'h0, 2'h3);
    wr(12'h7FC, 32'hFFFFFFFF, 2'h3);
    hwEvent <= 39'h0000100000;
    @(posedge clk);
    hwEvent <= 39'h0;
    slow <= 1'b1;
    wr(12'h100, 32'h00100000, 2'h0);
    chk("pending", 1'b1, irqPending[20]);
    chk("request", 39'h0000100000, irqRequest);
    repeat (12) @(posedge clk);
    chk("pending", 1'b0, irqPending[20]);
    chk("request", 39'h0, irqRequest);
    repeat (3) @(posedge clk);
    close_out;
  end
endmodule // irq_enable_pending_regs_test
